// ### tms_smbus_regs.sv
// Serial-bus slave and control registers of the two-channel temperature monitor
//
// Summary of operation
// [R1] Config bit 6 clear keeps converting; set enters standby; resets to zero.
// [R2] Low level on the standby pin also forces standby.
// [R3] Value registers keep their contents in standby, except after a triggered conversion.
// [R4] Config bit 7 set masks the interrupt output; clear lets it assert.
// [R5] Mask resets to zero; reserved config bits 5..0 reset and read zero.
// [R6] Rate bits 2..0 pick divider 1..128; code 7 fastest, code 0 slowest.
// [R7] Host writes zero to rate bits 7..3 and avoids codes 08h..FFh.
// [R8] Rate register is written over the bus and reads back as stored.
// [R9] High alarm on strictly greater, low alarm on strictly less.
// [R10] Four signed limit registers, readable and writable.
// [R11] Trigger write in config-bit standby with the pin high runs exactly one conversion then stays in standby.
// [R12] Data byte of the trigger write is ignored and not stored.
// [R13] Slave address comes from two three-level straps, nine addresses.
// [R14] Straps are sampled once after reset and then held.
// [R15] After START, seven address bits MSB first plus direction bit are shifted in.
// [R16] Acknowledge matched address and every received byte; otherwise stay idle.
// [R17] Host ends a read with not-acknowledge, then STOP.
// [R18] Direction is fixed per transfer; change needs a new START and address.
// [R19] First write byte loads the pointer; second is written to the selected register.
// [R20] Reads return the pointed register; pointer persists between transfers.
// [R21] Host loads the pointer with a one-byte write before a fresh read.
// [R22] Registers have separate read and write pointer values.
// [R23] Host loads the pointer before the first read after power-up.
// [R24] Write 0F triggers; config read 03 write 09; rate read 04 write 0A.
`timescale 1ns/1ps
module tms_smbus_regs #(
  parameter logic [31:0] CONV_FAST_CYCLES = tms_pkg::TMS_CONV_FAST_CYCLES,
  parameter logic [7:0]  MAKER_ID         = tms_pkg::TMS_MAKER_ID_DEFAULT,
  parameter logic [7:0]  REVISION         = tms_pkg::TMS_REVISION_DEFAULT
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Serial bus pins
  input  wire logic       serialClock,
  input  wire logic       serialDataIn,
  output logic            serialDataOut,
  output logic            serialDataOe,
  // Interrupt pin, open drain
  output logic            irqOut,
  output logic            irqOe,
  // Control and strap pins
  input  wire logic       sleep_request_n,
  input  wire logic [1:0] addr_strap_a,
  input  wire logic [1:0] addr_strap_b,
  // Converter
  input  wire logic       measDone,
  input  wire logic [7:0] localMeas,
  input  wire logic [7:0] remoteMeas,
  output logic            convStart,
  output logic            convBusy
);

  typedef enum logic [2:0] {
    BUS_IDLE     = 3'b000,
    BUS_ADDR     = 3'b001,
    BUS_ACK_ADDR = 3'b010,
    BUS_WRITE    = 3'b011,
    BUS_ACK_WR   = 3'b100,
    BUS_READ     = 3'b101,
    BUS_READ_ACK = 3'b110
  } tms_bus_state_t;

  tms_bus_state_t busState;

  logic       sclMeta;
  logic       sclSync;
  logic       sclPrev;
  logic       sdaMeta;
  logic       sdaSync;
  logic       sdaPrev;
  logic       sleepMeta;
  logic       sleepSync;
  logic       startSeen;
  logic       stopSeen;
  logic       sclRise;
  logic       sclFall;
  logic [3:0] bitCnt;
  logic [7:0] rxShift;
  logic [7:0] txShift;
  logic       readDir;
  logic [1:0] byteCnt;
  logic       hostNack;
  logic       wrCommit;
  logic       regWrite;
  logic       oneShot;
  logic [7:0] pointer;
  logic       cfgMask;
  logic       cfgStandby;
  logic [7:0] rateReg;
  logic [7:0] limitReg [4];
  logic [7:0] localVal;
  logic [7:0] remoteVal;
  logic [7:0] statusByte;
  logic [7:0] readByte;
  logic       localHigh;
  logic       localLow;
  logic       remoteHigh;
  logic       remoteLow;
  logic       resultAccept;
  logic [6:0] slaveAddr;
  logic       addrValid;
  logic [7:0] wrLimitIdx;
  logic [7:0] rdLimitIdx;

  tms_strap_latch u_strap (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .addrStrapA (addr_strap_a),
    .addrStrapB (addr_strap_b),
    .slaveAddr  (slaveAddr),
    .addrValid  (addrValid)
  );

  tms_conv_ctrl #(
    .CONV_FAST_CYCLES (CONV_FAST_CYCLES)
  ) u_conv (
    .ref_clk      (ref_clk),
    .reset        (reset),
    .softStandby  (cfgStandby),
    .pinStandby   (!sleepSync),
    .oneShot      (oneShot),
    .rateCode     (rateReg[2:0]),
    .measDone     (measDone),
    .convStart    (convStart),
    .convBusy     (convBusy),
    .resultAccept (resultAccept)
  );

  // Pin synchronisers
  always_ff @(posedge ref_clk) begin
    sclMeta   <= serialClock;
    sclSync   <= sclMeta;
    sdaMeta   <= serialDataIn;
    sdaSync   <= sdaMeta;
    sleepMeta <= sleep_request_n;
    sleepSync <= sleepMeta;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sclPrev <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclPrev <= sclSync;
      sdaPrev <= sdaSync;
    end
  end

  assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
  assign stopSeen  = sclSync && sclPrev && !sdaPrev && sdaSync;
  assign sclRise   = sclSync && !sclPrev;
  assign sclFall   = !sclSync && sclPrev;

  // Byte boundaries of a write transfer
  assign wrCommit = (busState == BUS_WRITE) && sclFall && (bitCnt == 4'h8);
  assign regWrite = wrCommit && (byteCnt == 2'h1); // [R19]
  assign oneShot  = regWrite && (pointer == tms_pkg::TMS_WR_ONESHOT); // [R24] [R12]

  // Bus state machine
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      busState     <= BUS_IDLE;
      bitCnt       <= 4'h0;
      rxShift      <= 8'h00;
      txShift      <= 8'h00;
      readDir      <= 1'b0;
      byteCnt      <= 2'h0;
      hostNack     <= 1'b0;
      serialDataOe <= 1'b0;
    end else if (startSeen) begin
      // A repeated START also restarts here, so direction is chosen anew
      busState     <= BUS_ADDR; // [R15] [R18]
      bitCnt       <= 4'h0;
      byteCnt      <= 2'h0;
      serialDataOe <= 1'b0;
    end else if (stopSeen) begin
      busState     <= BUS_IDLE;
      serialDataOe <= 1'b0;
    end else begin
      unique case (busState)
        BUS_IDLE: begin
          serialDataOe <= 1'b0;
        end
        BUS_ADDR, BUS_WRITE: begin
          if (sclRise) begin
            rxShift <= {rxShift[6:0], sdaSync}; // [R15]
            bitCnt  <= bitCnt + 4'h1;
          end else if (sclFall && bitCnt == 4'h8) begin
            bitCnt <= 4'h0;
            if (busState == BUS_WRITE) begin
              busState     <= BUS_ACK_WR;
              serialDataOe <= 1'b1; // [R16]
              if (byteCnt != 2'h3) begin
                byteCnt <= byteCnt + 2'h1;
              end
            end else if (addrValid && rxShift[7:1] == slaveAddr) begin
              busState     <= BUS_ACK_ADDR;
              serialDataOe <= 1'b1; // [R16]
              readDir      <= rxShift[0]; // [R18]
            end else begin
              busState <= BUS_IDLE; // [R16]
            end
          end
        end
        BUS_ACK_ADDR: begin
          if (sclFall) begin
            bitCnt <= 4'h0;
            if (readDir) begin
              txShift      <= readByte; // [R20]
              serialDataOe <= !readByte[7];
              busState     <= BUS_READ;
            end else begin
              serialDataOe <= 1'b0;
              busState     <= BUS_WRITE;
            end
          end
        end
        BUS_ACK_WR: begin
          if (sclFall) begin
            serialDataOe <= 1'b0;
            busState     <= BUS_WRITE;
          end
        end
        BUS_READ: begin
          if (sclRise) begin
            bitCnt <= bitCnt + 4'h1;
          end else if (sclFall) begin
            if (bitCnt == 4'h8) begin
              bitCnt       <= 4'h0;
              serialDataOe <= 1'b0;
              busState     <= BUS_READ_ACK;
            end else begin
              txShift      <= {txShift[6:0], 1'b0};
              serialDataOe <= !txShift[6];
            end
          end
        end
        BUS_READ_ACK: begin
          if (sclRise) begin
            hostNack <= sdaSync; // [R17]
          end else if (sclFall) begin
            if (hostNack) begin
              busState <= BUS_IDLE;
            end else begin
              // Further bytes repeat the pointed register
              txShift      <= readByte;
              serialDataOe <= !readByte[7];
              busState     <= BUS_READ;
            end
          end
        end
        default: begin
          busState     <= BUS_IDLE;
          serialDataOe <= 1'b0;
        end
      endcase
    end
  end

  // Data line is only ever pulled low
  always_ff @(posedge ref_clk) begin
    serialDataOut <= 1'b0;
    irqOut        <= 1'b0;
  end

  // Pointer, kept across transfers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pointer <= tms_pkg::TMS_POINTER_RESET;
    end else if (wrCommit && byteCnt == 2'h0) begin
      pointer <= rxShift; // [R19] [R20]
    end
  end

  // Configuration and rate
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfgMask    <= 1'b0; // [R5]
      cfgStandby <= 1'b0; // [R1]
      rateReg    <= tms_pkg::TMS_RATE_RESET;
    end else if (regWrite) begin
      if (pointer == tms_pkg::TMS_WR_CONFIG) begin
        cfgMask    <= rxShift[tms_pkg::TMS_CFG_MASK_BIT]; // [R24] [R4]
        cfgStandby <= rxShift[tms_pkg::TMS_CFG_STANDBY_BIT]; // [R1]
      end
      if (pointer == tms_pkg::TMS_WR_RATE) begin
        rateReg <= rxShift; // [R8] [R24]
      end
    end
  end

  assign wrLimitIdx = pointer - tms_pkg::TMS_WR_LIMIT_FIRST;
  assign rdLimitIdx = pointer - tms_pkg::TMS_RD_LIMIT_FIRST;

  // Limit registers
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_limit
      always_ff @(posedge ref_clk) begin
        if (reset) begin
          limitReg[gi] <= tms_pkg::TMS_LIMIT_RESET[gi];
        end else if (regWrite && pointer >= tms_pkg::TMS_WR_LIMIT_FIRST
                     && pointer <= tms_pkg::TMS_WR_LIMIT_LAST
                     && wrLimitIdx[1:0] == 2'(gi)) begin
          limitReg[gi] <= rxShift; // [R10]
        end
      end
    end
  endgenerate

  // Value registers change only on a completed conversion; in standby only after a trigger write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      localVal  <= tms_pkg::TMS_VALUE_RESET;
      remoteVal <= tms_pkg::TMS_VALUE_RESET;
    end else if (resultAccept) begin
      localVal  <= localMeas; // [R3]
      remoteVal <= remoteMeas; // [R3]
    end
  end

  // Signed comparisons; limits may be negative
  assign localHigh  = $signed(localVal) > $signed(limitReg[0]); // [R9] [R10]
  assign localLow   = $signed(localVal) < $signed(limitReg[1]); // [R9]
  assign remoteHigh = $signed(remoteVal) > $signed(limitReg[2]); // [R9]
  assign remoteLow  = $signed(remoteVal) < $signed(limitReg[3]); // [R9]

  always_comb begin
    statusByte = 8'h00;
    statusByte[tms_pkg::TMS_ST_BUSY_BIT]  = convBusy;
    statusByte[tms_pkg::TMS_ST_LHIGH_BIT] = localHigh;
    statusByte[tms_pkg::TMS_ST_LLOW_BIT]  = localLow;
    statusByte[tms_pkg::TMS_ST_RHIGH_BIT] = remoteHigh;
    statusByte[tms_pkg::TMS_ST_RLOW_BIT]  = remoteLow;
  end

  // Read selection; write-only pointer values return a fixed byte
  always_comb begin
    readByte = tms_pkg::TMS_UNMAPPED_READ; // [R22]
    if (pointer == tms_pkg::TMS_RD_LOCAL_VAL) begin
      readByte = localVal;
    end else if (pointer == tms_pkg::TMS_RD_REMOTE_VAL) begin
      readByte = remoteVal;
    end else if (pointer == tms_pkg::TMS_RD_STATUS) begin
      readByte = statusByte;
    end else if (pointer == tms_pkg::TMS_RD_CONFIG) begin
      readByte[tms_pkg::TMS_CFG_MASK_BIT]    = cfgMask; // [R5] [R24]
      readByte[tms_pkg::TMS_CFG_STANDBY_BIT] = cfgStandby;
    end else if (pointer == tms_pkg::TMS_RD_RATE) begin
      readByte = rateReg; // [R8] [R24]
    end else if (pointer >= tms_pkg::TMS_RD_LIMIT_FIRST
                 && pointer <= tms_pkg::TMS_RD_LIMIT_LAST) begin
      readByte = limitReg[rdLimitIdx[1:0]]; // [R10]
    end else if (pointer == tms_pkg::TMS_RD_MAKER_ID) begin
      readByte = MAKER_ID;
    end else if (pointer == tms_pkg::TMS_RD_REVISION) begin
      readByte = REVISION;
    end
  end

  // Mask also silences an alarm already present
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irqOe <= 1'b0;
    end else begin
      irqOe <= (localHigh | localLow | remoteHigh | remoteLow) & !cfgMask; // [R4]
    end
  end

endmodule

// ### tms_pkg.sv
// Shared constants for the temperature monitor serial-bus front end and registers
package tms_pkg;

  // Pointer values for reads
  localparam logic [7:0] TMS_RD_LOCAL_VAL   = 8'h00;
  localparam logic [7:0] TMS_RD_REMOTE_VAL  = 8'h01;
  localparam logic [7:0] TMS_RD_STATUS      = 8'h02;
  localparam logic [7:0] TMS_RD_CONFIG      = 8'h03;
  localparam logic [7:0] TMS_RD_RATE        = 8'h04;
  localparam logic [7:0] TMS_RD_LIMIT_FIRST = 8'h05;
  localparam logic [7:0] TMS_RD_LIMIT_LAST  = 8'h08;
  localparam logic [7:0] TMS_RD_MAKER_ID    = 8'hFE;
  localparam logic [7:0] TMS_RD_REVISION    = 8'hFF;

  // Pointer values for writes
  localparam logic [7:0] TMS_WR_CONFIG      = 8'h09;
  localparam logic [7:0] TMS_WR_RATE        = 8'h0A;
  localparam logic [7:0] TMS_WR_LIMIT_FIRST = 8'h0B;
  localparam logic [7:0] TMS_WR_LIMIT_LAST  = 8'h0E;
  localparam logic [7:0] TMS_WR_ONESHOT     = 8'h0F;

  // Configuration field positions
  localparam int TMS_CFG_MASK_BIT    = 7;
  localparam int TMS_CFG_STANDBY_BIT = 6;

  // Status field positions
  localparam int TMS_ST_BUSY_BIT   = 7;
  localparam int TMS_ST_LHIGH_BIT  = 6;
  localparam int TMS_ST_LLOW_BIT   = 5;
  localparam int TMS_ST_RHIGH_BIT  = 4;
  localparam int TMS_ST_RLOW_BIT   = 3;

  // Values after reset, and the byte read at unmapped pointers
  localparam logic [7:0] TMS_VALUE_RESET   = 8'h80;
  localparam logic [7:0] TMS_RATE_RESET    = 8'h02;
  localparam logic [7:0] TMS_POINTER_RESET = 8'h00;
  localparam logic [7:0] TMS_UNMAPPED_READ = 8'h00;
  localparam logic [7:0] TMS_LIMIT_RESET [4] = '{8'h7F, 8'hC9, 8'h7F, 8'hC9};

  // Identity bytes; values are arbitrary
  localparam logic [7:0] TMS_MAKER_ID_DEFAULT = 8'h5A;
  localparam logic [7:0] TMS_REVISION_DEFAULT = 8'hA5;

  // Slave address per strap pair, index is strapA*3 + strapB
  localparam logic [6:0] TMS_SLAVE_ADDR [9] = '{
    7'h18, 7'h19, 7'h1A, 7'h29, 7'h2A, 7'h2B, 7'h4C, 7'h4D, 7'h4E
  };

  // Strap pin coding on each 2-bit strap input
  localparam logic [1:0] TMS_STRAP_LOW  = 2'h0;
  localparam logic [1:0] TMS_STRAP_OPEN = 2'h1;
  localparam logic [1:0] TMS_STRAP_HIGH = 2'h2;

  // Timing
  localparam longint TMS_CLK_HZ       = 40000000;
  localparam longint TMS_CONV_FAST_MS = 125;
  localparam logic [31:0] TMS_CONV_FAST_CYCLES =
    32'(TMS_CLK_HZ * TMS_CONV_FAST_MS / 1000);
  localparam logic [2:0] TMS_RATE_FASTEST = 3'h7;
  localparam logic [1:0] TMS_STRAP_SETTLE = 2'h2;

endpackage

// ### tms_strap_latch.sv
// Latches the slave address from the two three-level strap pins once after reset
`timescale 1ns/1ps
module tms_strap_latch (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Strap pins
  input  wire logic [1:0] addrStrapA,
  input  wire logic [1:0] addrStrapB,
  // Latched address
  output logic      [6:0] slaveAddr,
  output logic            addrValid
);

  logic [1:0] strapAMeta;
  logic [1:0] strapASync;
  logic [1:0] strapBMeta;
  logic [1:0] strapBSync;
  logic [1:0] settleCnt;
  logic [3:0] tableIdx;

  always_ff @(posedge ref_clk) begin
    strapAMeta <= addrStrapA;
    strapASync <= strapAMeta;
    strapBMeta <= addrStrapB;
    strapBSync <= strapBMeta;
  end

  // Undefined code 3 is taken as open
  function automatic logic [3:0] levelOf(input logic [1:0] code);
    levelOf = (code == tms_pkg::TMS_STRAP_LOW)  ? 4'h0 :
              (code == tms_pkg::TMS_STRAP_HIGH) ? 4'h2 : 4'h1;
  endfunction

  assign tableIdx = 4'(levelOf(strapASync) * 4'h3 + levelOf(strapBSync));

  // Capture once after the synchronisers fill; later pin changes are ignored
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      settleCnt <= 2'h0;
      slaveAddr <= 7'h00;
      addrValid <= 1'b0;
    end else if (!addrValid) begin
      if (settleCnt == tms_pkg::TMS_STRAP_SETTLE) begin
        slaveAddr <= tms_pkg::TMS_SLAVE_ADDR[tableIdx]; // [R13]
        addrValid <= 1'b1; // [R14]
      end else begin
        settleCnt <= settleCnt + 2'h1;
      end
    end
  end

endmodule

// ### tms_conv_ctrl.sv
// Conversion scheduler: periodic runs, standby and the single conversion trigger
`timescale 1ns/1ps
module tms_conv_ctrl #(
  parameter logic [31:0] CONV_FAST_CYCLES = tms_pkg::TMS_CONV_FAST_CYCLES
) (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset,
  // Control
  input  wire logic       softStandby,
  input  wire logic       pinStandby,
  input  wire logic       oneShot,
  input  wire logic [2:0] rateCode,
  // Converter handshake
  input  wire logic       measDone,
  output logic            convStart,
  output logic            convBusy,
  output logic            resultAccept
);

  logic [31:0] periodCnt;
  logic [31:0] periodLoad;
  logic        singleRun;
  logic        standby;
  logic        abortNow;

  assign standby    = softStandby | pinStandby; // [R1] [R2]
  // Each step down in code doubles the period
  assign periodLoad = CONV_FAST_CYCLES << (tms_pkg::TMS_RATE_FASTEST - rateCode); // [R6]
  assign abortNow   = standby && !singleRun;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      periodCnt <= 32'h0000_0000;
    end else if (standby || periodCnt == 32'h0000_0000) begin
      periodCnt <= periodLoad - 32'h0000_0001;
    end else begin
      periodCnt <= periodCnt - 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      convStart    <= 1'b0;
      convBusy     <= 1'b0;
      singleRun    <= 1'b0;
      resultAccept <= 1'b0;
    end else begin
      convStart    <= 1'b0;
      resultAccept <= 1'b0;
      if (convBusy && (abortNow || (pinStandby && singleRun))) begin
        // Result of an interrupted conversion is discarded
        convBusy  <= 1'b0; // [R1]
        singleRun <= 1'b0;
      end else if (convBusy && measDone) begin
        convBusy     <= 1'b0;
        singleRun    <= 1'b0; // [R11]
        resultAccept <= 1'b1;
      end else if (!convBusy && softStandby && !pinStandby && oneShot) begin
        convStart <= 1'b1; // [R11]
        convBusy  <= 1'b1;
        singleRun <= 1'b1;
      end else if (!convBusy && !standby && periodCnt == 32'h0000_0000) begin
        convStart <= 1'b1; // [R1]
        convBusy  <= 1'b1;
      end
    end
  end

endmodule

// ### tms_host_model.sv
// Bus master model: drives the bus clock and pulls the data line low
`timescale 1ns/1ps
module tms_host_model #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic ref_clk,
  // Bus
  input  wire logic busLevel,
  output logic      serialClock,
  output logic      hostPullLow
);
  initial begin
    serialClock = 1'b1;
    hostPullLow = 1'b0;
  end

  task automatic w(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  // Two spare cycles after each fall keep data edges out of the synced high phase
  task automatic clk_pulse(output logic seen);
    w(HALF);
    serialClock = 1'b1;
    w(HALF);
    seen = busLevel;
    serialClock = 1'b0;
    w(2);
  endtask

  task automatic bus_start;
    hostPullLow = 1'b1;
    w(HALF);
    serialClock = 1'b0;
    w(2);
  endtask

  task automatic bus_stop;
    hostPullLow = 1'b1;
    w(HALF);
    serialClock = 1'b1;
    w(HALF);
    hostPullLow = 1'b0;
    w(HALF);
  endtask

  task automatic put_byte(input logic [7:0] b, output logic ackN);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      hostPullLow = !b[i];
      clk_pulse(s);
    end
    hostPullLow = 1'b0;
    clk_pulse(ackN);
  endtask

  task automatic get_byte(output logic [7:0] b, input logic last);
    logic s;
    hostPullLow = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      clk_pulse(b[i]);
    end
    hostPullLow = !last;
    clk_pulse(s);
  endtask
endmodule

// ### tms_smbus_regs_props.sv
// Concurrent checks on the pins of the serial-bus register block
`timescale 1ns/1ps
module tms_smbus_regs_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       reset,
  // Bus and interrupt pins
  input wire logic       serialClock,
  input wire logic       serialDataIn,
  input wire logic       serialDataOut,
  input wire logic       serialDataOe,
  input wire logic       irqOut,
  input wire logic       irqOe,
  // Control and straps
  input wire logic       sleep_request_n,
  input wire logic [1:0] addr_strap_a,
  input wire logic [1:0] addr_strap_b,
  // Converter
  input wire logic       measDone,
  input wire logic [7:0] localMeas,
  input wire logic [7:0] remoteMeas,
  input wire logic       convStart,
  input wire logic       convBusy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  data_open_drain_a: assert property (serialDataOut == 1'b0)
    else $error("data pin driven high");
  irq_open_drain_a: assert property (irqOut == 1'b0)
    else $error("interrupt pin driven high");
  start_sets_busy_a: assert property (convStart |-> ##[0:1] convBusy)
    else $error("start without busy");
  start_single_pulse_a: assert property (convStart |=> !convStart)
    else $error("start longer than one cycle");
  pin_standby_idle_a: assert property (!sleep_request_n [*6] |-> !convBusy && !convStart)
    else $error("converting with standby pin low");
  done_ends_busy_a: assert property (convBusy && measDone |=> !convBusy)
    else $error("busy held after done");
  reset_quiet_a: assert property ($fell(reset) |-> !serialDataOe && !irqOe && !convBusy)
    else $error("outputs active after reset");
  ack_steady_high_a: assert property (serialClock [*4] |-> $stable(serialDataOe))
    else $error("data drive changed while clock high");

  cover property (convStart);
  cover property ($rose(serialDataOe));
  cover property ($rose(irqOe));
endmodule

bind tms_smbus_regs tms_smbus_regs_chk u_chk (
  .ref_clk(ref_clk), .reset(reset), .serialClock(serialClock),
  .serialDataIn(serialDataIn), .serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
  .irqOut(irqOut), .irqOe(irqOe), .sleep_request_n(sleep_request_n),
  .addr_strap_a(addr_strap_a), .addr_strap_b(addr_strap_b), .measDone(measDone),
  .localMeas(localMeas), .remoteMeas(remoteMeas), .convStart(convStart),
  .convBusy(convBusy)
);

// ### tb.sv
// Self-checking bench for the serial-bus register block
`timescale 1ns/1ps
module tb;
  // Straps open and high select this address
  localparam logic [6:0] DEV = 7'b0101011;
  logic       ref_clk;
  logic       reset;
  logic       sleep_request_n;
  logic [1:0] addr_strap_a;
  logic [1:0] addr_strap_b;
  logic [7:0] localMeas;
  logic [7:0] remoteMeas;
  logic       measDone = 1'b0;
  logic       startDly = 1'b0;
  logic       serialClock, hostPullLow, sdaLine, serialDataOut, serialDataOe;
  logic       irqOut, irqOe, convStart, convBusy, ack;
  logic [7:0] rd;
  int         n_mismatch = 0;
  int         num_checks = 0;
  int         cycles = 0;
  int         starts = 0;
  int         snap;

  // Pull-up on the data line
  assign sdaLine = !(hostPullLow | serialDataOe);

  tms_smbus_regs #(.CONV_FAST_CYCLES(32'd16)) u_dut (
    .ref_clk(ref_clk), .reset(reset), .serialClock(serialClock), .serialDataIn(sdaLine),
    .serialDataOut(serialDataOut), .serialDataOe(serialDataOe), .irqOut(irqOut),
    .irqOe(irqOe), .sleep_request_n(sleep_request_n), .addr_strap_a(addr_strap_a),
    .addr_strap_b(addr_strap_b), .measDone(measDone), .localMeas(localMeas),
    .remoteMeas(remoteMeas), .convStart(convStart), .convBusy(convBusy)
  );
  tms_host_model u_host (
    .ref_clk(ref_clk), .busLevel(sdaLine), .serialClock(serialClock),
    .hostPullLow(hostPullLow)
  );

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Converter stand-in answers two cycles after each start; also the hang limit
  always @(posedge ref_clk) begin
    startDly <= convStart;
    measDone <= startDly;
    if (convStart) starts <= starts + 1;
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      finish_test;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] ptr, input logic [7:0] data, input logic two);
    u_host.bus_start;
    u_host.put_byte({DEV, 1'b0}, ack);
    check({7'h00, ack}, 8'h00, "address ack");
    u_host.put_byte(ptr, ack);
    check({7'h00, ack}, 8'h00, "pointer ack");
    if (two) begin
      u_host.put_byte(data, ack);
      check({7'h00, ack}, 8'h00, "data ack");
    end
    u_host.bus_stop;
  endtask

  task automatic rd_at(input logic [7:0] ptr, input logic [7:0] exp);
    reg_wr(ptr, 8'h00, 1'b0);
    u_host.bus_start;
    u_host.put_byte({DEV, 1'b1}, ack);
    check({7'h00, ack}, 8'h00, "read address ack");
    u_host.get_byte(rd, 1'b1);
    u_host.bus_stop;
    check(rd, exp, "read data");
  endtask

  task automatic done_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    reset = 1'b1;
    sleep_request_n = 1'b1;
    addr_strap_a = 2'h1;
    addr_strap_b = 2'h2;
    localMeas = 8'h05;
    remoteMeas = 8'h00;
    repeat (20) @(posedge ref_clk);
    #1 reset = 1'b0;
    u_host.w(10);
    // Strap changes after the latch must be ignored
    addr_strap_a = 2'h2;
    addr_strap_b = 2'h0;
    rd_at(8'h03, 8'h00);
    rd_at(8'h04, 8'h02);
    for (int i = 0; i < 4; i++) rd_at(8'h05 + 8'(i), tms_pkg::TMS_LIMIT_RESET[i]);
    done_test("reset values");
    u_host.bus_start;
    u_host.put_byte({7'b1001100, 1'b0}, ack);
    check({7'h00, ack}, 8'h01, "foreign address");
    u_host.bus_stop;
    for (int c = 0; c < 8; c++) begin
      reg_wr(8'h0A, 8'(c), 1'b1);
      rd_at(8'h04, 8'(c));
    end
    snap = starts;
    u_host.w(160);
    check(8'(starts - snap), 8'h0A, "rate 7 period");
    rd_at(8'h0A, tms_pkg::TMS_UNMAPPED_READ);
    done_test("rate and pointers");
    reg_wr(8'h0B, 8'h10, 1'b1);
    reg_wr(8'h0C, 8'hF0, 1'b1);
    reg_wr(8'h0D, 8'h60, 1'b1);
    reg_wr(8'h0E, 8'h80, 1'b1);
    rd_at(8'h06, 8'hF0);
    rd_at(8'h08, 8'h80);
    // Equal to a limit is no alarm; one past it is
    localMeas = 8'h10;
    u_host.w(100);
    check({7'h00, irqOe}, 8'h00, "high equal");
    localMeas = 8'h11;
    u_host.w(100);
    check({7'h00, irqOe}, 8'h01, "high above");
    localMeas = 8'hF0;
    u_host.w(100);
    check({7'h00, irqOe}, 8'h00, "low equal");
    localMeas = 8'hEF;
    u_host.w(100);
    check({7'h00, irqOe}, 8'h01, "low below");
    localMeas = 8'h10;
    remoteMeas = 8'h61;
    u_host.w(100);
    check({7'h00, irqOe}, 8'h01, "remote high");
    reg_wr(8'h09, 8'h80, 1'b1);
    u_host.w(20);
    check({7'h00, irqOe}, 8'h00, "masked alarm");
    rd_at(8'h03, 8'h80);
    done_test("limits and mask");
    localMeas = 8'h22;
    reg_wr(8'h09, 8'h40, 1'b1);
    u_host.w(50);
    snap = starts;
    localMeas = 8'h23;
    u_host.w(200);
    check(8'(starts), 8'(snap), "soft standby");
    reg_wr(8'h0F, 8'hAB, 1'b1);
    u_host.w(200);
    check(8'(starts), 8'(snap + 1), "single run");
    rd_at(8'h03, 8'h40);
    rd_at(8'h00, 8'h23);
    done_test("standby and trigger");
    reg_wr(8'h09, 8'h00, 1'b1);
    localMeas = 8'h33;
    u_host.w(60);
    sleep_request_n = 1'b0;
    u_host.w(20);
    snap = starts;
    localMeas = 8'h44;
    remoteMeas = 8'h45;
    u_host.w(200);
    check(8'(starts), 8'(snap), "pin standby");
    rd_at(8'h00, 8'h33);
    rd_at(8'h01, 8'h61);
    sleep_request_n = 1'b1;
    done_test("pin standby");
    finish_test;
  end
endmodule
